// ---- verilog/srctl_cfg.svh ----
// offsets, field positions, mode codes and timing counts of the sleep/reset controller
// assumes a 200 MHz pclk and 32-bit apb with byte addresses
`ifndef SRCTL_CFG_SVH
`define SRCTL_CFG_SVH

// register byte offsets
`define SRC_OFF_CTRL 12'h000
`define SRC_OFF_SLEEP 12'h004
`define SRC_OFF_STAT 12'h008

// control fields
`define SRC_CTRL_SE 0
`define SRC_CTRL_SM_LO 1
`define SRC_CTRL_SM_HI 3
`define SRC_CTRL_RST 32'h0000_0000

// sleep command field
`define SRC_SLEEP_GO 0

// status fields
`define SRC_STAT_ST_LO 0
`define SRC_STAT_ST_HI 1
`define SRC_STAT_MD_LO 2
`define SRC_STAT_MD_HI 4
`define SRC_STAT_WK_EXT 5
`define SRC_STAT_WK_OTH 6

// sleep mode codes, 3'h4 and 3'h5 unused
`define SRC_M_IDLE 3'h0
`define SRC_M_ADC 3'h1
`define SRC_M_PDN 3'h2
`define SRC_M_PSV 3'h3
`define SRC_M_STB 3'h6
`define SRC_M_XSTB 3'h7

// boundary-scan input pins within the 32 port pins
`define SRC_JTAG_PINS 32'h002c_0000

// timing
`define SRC_CLK_MHZ 200
`define SRC_OSC_START_NS 1000
`define SRC_RESTART_NS 10
`define SRC_OSC_START_CYC ((`SRC_OSC_START_NS * `SRC_CLK_MHZ + 999) / 1000)
`define SRC_RESTART_CYC ((`SRC_RESTART_NS * `SRC_CLK_MHZ + 999) / 1000)

`endif

// ---- verilog/srctl_pkg.sv ----
// types shared by the sleep/reset controller
// assumes nothing beyond a systemverilog package scope
package srctl_pkg;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} srctl_state_t;

  // clock domain enables
  typedef struct packed {
    logic cpu;
    logic io;
    logic adc;
    logic irq;
    logic tmr;
    logic osc;
  } srctl_dom_t;

endpackage : srctl_pkg

// ---- verilog/srctl_sync.sv ----
// three-flop input synchroniser, one per bit
// assumes inputs from outside the pclk domain
`timescale 1ns/100ps
module srctl_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins and filtered levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [2:0] s_q;
    logic o_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s_q <= {3{RST[i]}};
        o_q <= RST[i];
      end else begin
        s_q <= {s_q[1:0], din[i]};
        // change counts only once 2nd and 3rd agree
        if (s_q[1] == s_q[2]) begin
          o_q <= s_q[2];
        end
      end
    end
    assign dout[i] = o_q;
  end

endmodule : srctl_sync

// ---- verilog/srctl_rstgen.sv ----
// device reset: asynchronous assert from pin or bus reset, synchronous release
// assumes the pin reset may arrive with pclk stopped
`timescale 1ns/100ps
module srctl_rstgen (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rst_pin_n,
  // combined device reset
  output logic dev_rst_n
);

  logic arst_n;
  logic [2:0] sh_q;

  // no clock needed to assert
  assign arst_n = presetn & rst_pin_n;

  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q <= 3'h0;
      dev_rst_n <= 1'b0;
    end else begin
      sh_q <= {sh_q[1:0], 1'b1};
      dev_rst_n <= sh_q[1] & sh_q[2];
    end
  end

  property p_rst_hold;
    @(posedge pclk) disable iff (!presetn) !rst_pin_n |-> !dev_rst_n;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("pin reset low but device reset released");

  property p_rst_rel;
    @(posedge pclk) disable iff (!presetn) rst_pin_n [*5] |-> dev_rst_n;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("device reset not released after pin release");

endmodule : srctl_rstgen

// ---- verilog/srctl_top.sv ----
// sleep mode and reset controller: apb registers, sleep fsm, pin hi-z
// assumes an always-on pclk for this block; core domains gated by dom
//
// Overview of operation
// - idle: cpu stops, peripherals and irq clocked
// - power-down: oscillator off, wake on pin/reset
// - power-save: async timer keeps counting
// - adc noise mode: adc, timer, irq and oscillator run
// - standby: oscillator runs, rest sleeps
// - extended standby: oscillator and timer run
// - six modes, software selects which
// - long reset pin low resets without clock
// - reset floats all port pins asynchronously
// - scan pull-ups stay on during reset
`timescale 1ns/100ps
`include "srctl_cfg.svh"
module srctl_top
  import srctl_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset and wake sources
  input wire logic rst_pin_n,
  input wire logic [2:0] ext_irq_n,
  input wire logic tmr_irq,
  input wire logic per_irq,
  input wire logic adc_irq,
  // scan enable fuse
  input wire logic jtag_fuse_en,
  // port pin control from the core
  input wire logic [31:0] core_oe_n,
  input wire logic [31:0] core_pu_en,
  // port pin control to the pads
  output logic [31:0] pin_oe_n,
  output logic [31:0] pin_pu_en,
  // domain control
  output srctl_dom_t dom,
  output logic dev_rst_n,
  output logic sleeping
);

  // ------------------------------------------------------------
  // constants
  // ------------------------------------------------------------
  localparam int OSC_CYC = `SRC_OSC_START_CYC;
  localparam int RES_CYC = `SRC_RESTART_CYC;
  localparam int WAKE_MAX = OSC_CYC + 2;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m != 3'h4) && (m != 3'h5);
  endfunction : mode_ok

  // what keeps running in each sleep mode
  function automatic srctl_dom_t dom_of(input logic [2:0] m);
    srctl_dom_t d;
    d = '0;
    case (m)
      `SRC_M_IDLE: begin
        d.io = 1'b1;
        d.adc = 1'b1;
        d.irq = 1'b1;
        d.tmr = 1'b1;
        d.osc = 1'b1;
      end
      `SRC_M_ADC: begin
        d.adc = 1'b1;
        d.irq = 1'b1;
        d.tmr = 1'b1;
        d.osc = 1'b1;
      end
      `SRC_M_PSV: begin
        d.tmr = 1'b1;
      end
      `SRC_M_STB: begin
        d.osc = 1'b1;
      end
      `SRC_M_XSTB: begin
        d.osc = 1'b1;
        d.tmr = 1'b1;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction : dom_of

  // ------------------------------------------------------------
  // reset and input synchronisers
  // ------------------------------------------------------------
  logic [3:0] sync_s;
  logic ext_wake;
  logic tmr_wake;

  srctl_rstgen u_rst (
    .pclk(pclk),
    .presetn(presetn),
    .rst_pin_n(rst_pin_n),
    .dev_rst_n(dev_rst_n)
  );

  // pin wake needs pclk; this block must sit on the always-on clock
  srctl_sync #(.W(4), .RST(4'h7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({tmr_irq, ext_irq_n}),
    .dout(sync_s)
  );

  assign ext_wake = ~&sync_s[2:0];
  assign tmr_wake = sync_s[3];

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic sel_ctrl;
  logic sel_sleep;
  logic sel_stat;
  logic mapped;
  logic wr_en;
  logic rd_setup;
  logic [2:0] wr_mode;

  assign sel_ctrl = paddr == `SRC_OFF_CTRL;
  assign sel_sleep = paddr == `SRC_OFF_SLEEP;
  assign sel_stat = paddr == `SRC_OFF_STAT;
  assign mapped = sel_ctrl | sel_sleep | sel_stat;
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_mode = pwdata[`SRC_CTRL_SM_HI:`SRC_CTRL_SM_LO];

  // zero wait states; read data loaded in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  logic se_q;
  logic [2:0] mode_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se_q <= 1'(`SRC_CTRL_RST);
      mode_q <= `SRC_M_IDLE;
    end else if (wr_en && sel_ctrl) begin
      se_q <= pwdata[`SRC_CTRL_SE];
      // unused codes leave the mode unchanged
      if (mode_ok(wr_mode)) begin
        mode_q <= wr_mode;
      end
    end
  end

  // ------------------------------------------------------------
  // sleep fsm
  // ------------------------------------------------------------
  srctl_state_t st_q;
  srctl_state_t st_d;
  logic [2:0] act_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic go;
  logic wake;
  srctl_dom_t ds;
  srctl_dom_t dom_d;

  assign go = wr_en & sel_sleep & pwdata[`SRC_SLEEP_GO] & se_q & (st_q == ST_RUN);
  assign ds = dom_of(act_q);

  // pin interrupts always wake; other sources only while their clock runs
  assign wake = ext_wake
    | (ds.io & per_irq)
    | (ds.tmr & tmr_wake)
    | (ds.adc & adc_irq);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_RUN: begin
        if (go) begin
          st_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          st_d = ST_WAKE;
          // a stopped oscillator needs its full start-up
          if (ds.osc) begin
            cnt_d = 8'(RES_CYC - 1);
          end else begin
            cnt_d = 8'(OSC_CYC - 1);
          end
        end
      end
      ST_WAKE: begin
        if (cnt_q == 8'h00) begin
          st_d = ST_RUN;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  // enables follow the next state so dom matches st_q
  always_comb begin
    case (st_d)
      ST_SLEEP: begin
        dom_d = (st_q == ST_RUN) ? dom_of(mode_q) : ds;
      end
      ST_WAKE: begin
        dom_d = '0;
        dom_d.osc = 1'b1;
        dom_d.tmr = 1'b1;
        dom_d.irq = 1'b1;
      end
      default: begin
        dom_d = '1;
      end
    endcase
  end

  // registers and sram are never cleared here, only gated
  always_ff @(posedge pclk or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      st_q <= ST_RUN;
      cnt_q <= 8'h00;
      act_q <= `SRC_M_IDLE;
      dom <= '1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dom <= dom_d;
      if (go) begin
        act_q <= mode_q;
      end
    end
  end

  assign sleeping = st_q != ST_RUN;

  // ------------------------------------------------------------
  // wake cause flags, write one to clear
  // ------------------------------------------------------------
  logic [1:0] wk_q;
  logic [1:0] wk_set;
  logic [1:0] wk_clr;

  assign wk_set = {(st_q == ST_SLEEP) & wake & ~ext_wake,
                   (st_q == ST_SLEEP) & ext_wake};
  assign wk_clr = (wr_en && sel_stat) ?
    {pwdata[`SRC_STAT_WK_OTH], pwdata[`SRC_STAT_WK_EXT]} : 2'h0;

  // a wake in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_q <= 2'h0;
    end else begin
      wk_q <= (wk_q & ~wk_clr) | wk_set;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  assign ctrl_rd = {28'h0, mode_q, se_q};
  assign stat_rd = {25'h0, wk_q, act_q, st_q};
  assign rd_mux = sel_ctrl ? ctrl_rd : (sel_stat ? stat_rd : 32'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // pad control
  // ------------------------------------------------------------
  logic [31:0] scan_pu;

  // combinational on purpose: must float with no clock
  assign pin_oe_n = core_oe_n | {32{~dev_rst_n}};

  assign scan_pu = jtag_fuse_en ? `SRC_JTAG_PINS : 32'h0;
  assign pin_pu_en = (dev_rst_n ? core_pu_en : 32'h0) | scan_pu;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic in_sleep;
  assign in_sleep = st_q == ST_SLEEP;

  default clocking chk_cb @(posedge pclk); endclocking
  property p_idle;
    disable iff (!dev_rst_n)
      in_sleep && act_q == `SRC_M_IDLE |-> !dom.cpu && dom.io && dom.adc && dom.irq;
  endproperty
  a_idle: assert property (p_idle) else $error("idle mode clocks wrong");
  property p_pdown;
    disable iff (!dev_rst_n) in_sleep && act_q == `SRC_M_PDN |-> dom == '0;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down left a clock running");
  property p_psave;
    disable iff (!dev_rst_n)
      in_sleep && act_q == `SRC_M_PSV |-> dom.tmr && !dom.io && !dom.osc && !dom.cpu;
  endproperty
  a_psave: assert property (p_psave) else $error("power-save timer not running");
  property p_adcnr;
    disable iff (!dev_rst_n)
      in_sleep && act_q == `SRC_M_ADC |-> dom.adc && dom.tmr && !dom.io && !dom.cpu;
  endproperty
  a_adcnr: assert property (p_adcnr) else $error("adc noise mode clocks wrong");
  property p_stby;
    disable iff (!dev_rst_n) in_sleep && act_q == `SRC_M_STB |-> dom.osc && !dom.tmr && !dom.io;
  endproperty
  a_stby: assert property (p_stby) else $error("standby oscillator not running");
  property p_xstby;
    disable iff (!dev_rst_n) in_sleep && act_q == `SRC_M_XSTB |-> dom.osc && dom.tmr && !dom.cpu;
  endproperty
  a_xstby: assert property (p_xstby) else $error("extended standby clocks wrong");
  property p_mode;
    disable iff (!presetn) wr_en && sel_ctrl && !mode_ok(wr_mode) |=> mode_q == $past(mode_q);
  endproperty
  a_mode: assert property (p_mode) else $error("unused mode code accepted");
  property p_hiz;
    !dev_rst_n |-> pin_oe_n == 32'hffff_ffff;
  endproperty
  a_hiz: assert property (p_hiz) else $error("port pin driven during reset");
  property p_scan;
    jtag_fuse_en && !dev_rst_n |-> (pin_pu_en & `SRC_JTAG_PINS) == `SRC_JTAG_PINS;
  endproperty
  a_scan: assert property (p_scan) else $error("scan pull-ups lost in reset");
  property p_wake;
    disable iff (!dev_rst_n) in_sleep && wake
      |=> st_q == ST_WAKE ##[1:WAKE_MAX] st_q == ST_RUN && dom == '1;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restart clocks");
  property p_keep;
    disable iff (!dev_rst_n) st_q != ST_RUN && !(wr_en && sel_ctrl)
      |=> mode_q == $past(mode_q) && se_q == $past(se_q) && act_q == $past(act_q);
  endproperty
  a_keep: assert property (p_keep) else $error("sleep changed control contents");

endmodule : srctl_top

// ---- verif/srctl_src_model.sv ----
// external reset source and wake interrupt pins of the sleep/reset controller
// assumes the bench raises rst_go or irq_go by nba just after a pclk edge
`timescale 1ns/100ps
module srctl_src_model #(
  parameter int RST_LEN = 4
) (
  // clock
  input wire logic pclk,
  // commands from the bench
  input wire logic rst_go,
  input wire logic [2:0] irq_go,
  // pins
  output logic rst_pin_n,
  output logic [2:0] ext_irq_n
);
  // ----------------------------------------
  // reset pulse
  // ----------------------------------------
  logic [7:0] cnt_q = 8'h00;

  // pulse held the full minimum length, a short one is not guaranteed
  always_ff @(posedge pclk) begin
    if (rst_go) begin
      cnt_q <= 8'(RST_LEN);
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign rst_pin_n = (cnt_q == 8'h00);

  // level interrupts, held by the bench until the wake is seen
  assign ext_irq_n = ~irq_go;
endmodule : srctl_src_model

// ---- verif/sleep_and_reset_control_tb.sv ----
// testbench: apb tasks, sleep mode sweep, wake, pin reset and pin float checks
// assumes srctl_top and srctl_src_model, pclk at 200 MHz
`timescale 1ns/100ps
`include "srctl_cfg.svh"
module sleep_and_reset_control_tb;
  import srctl_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] core_oe_n = 32'h00ff_0f0f;
  logic [31:0] core_pu_en = 32'h0000_00f0;
  logic rst_go = 1'b0;
  logic per_irq = 1'b0;
  logic tmr_irq = 1'b0;
  logic adc_irq = 1'b0;
  logic fuse = 1'b1;
  logic [2:0] irq_go = 3'h0;
  logic [31:0] prdata, pin_oe_n, pin_pu_en, rd;
  logic pready, pslverr, rst_pin_n, dev_rst_n, sleeping, err;
  logic [2:0] ext_irq_n;
  srctl_dom_t dom;
  int mismatches = 0;
  int checks_done = 0;
  // mode codes, expected domains and the bits fixed for each
  localparam logic [2:0] MODES [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  localparam logic [5:0] DEXP [6] = '{6'h1f, 6'h0a, 6'h00, 6'h02, 6'h01, 6'h03};
  localparam logic [5:0] DMSK [6] = '{6'h3f, 6'h3a, 6'h3f, 6'h3e, 6'h3b, 6'h3b};

  always #2.5 pclk = ~pclk;

  srctl_src_model src_u (.pclk(pclk), .rst_go(rst_go), .irq_go(irq_go),
    .rst_pin_n(rst_pin_n), .ext_irq_n(ext_irq_n));

  srctl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rst_pin_n(rst_pin_n), .ext_irq_n(ext_irq_n), .tmr_irq(tmr_irq),
    .per_irq(per_irq), .adc_irq(adc_irq), .jtag_fuse_en(fuse), .core_oe_n(core_oe_n),
    .core_pu_en(core_pu_en), .pin_oe_n(pin_oe_n), .pin_pu_en(pin_pu_en), .dom(dom),
    .dev_rst_n(dev_rst_n), .sleeping(sleeping));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checks_done++;
    if ((got & msk) !== (exp & msk)) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stall(input string what);
    mismatches++;
    $display("[ERR] %0t no %s", $time, what);
    give_verdict();
  endtask : stall

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) stall("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_wake;
    int n = 0;
    while (sleeping !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) stall("wake");
  endtask : wait_wake

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (15) @(posedge pclk);
    #1;
    chk(32'(dev_rst_n), 32'h0, 32'h1);
    chk(pin_oe_n, 32'hffff_ffff, 32'hffff_ffff);
    chk(pin_pu_en, `SRC_JTAG_PINS, `SRC_JTAG_PINS);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    #1;
    chk(32'(dev_rst_n), 32'h1, 32'h1);
    chk(pin_oe_n, core_oe_n, 32'hffff_ffff);
    chk(pin_pu_en, core_pu_en | `SRC_JTAG_PINS, 32'hffff_ffff);
    chk(32'(dom), 32'h3f, 32'h3f);
    apb(1'b0, `SRC_OFF_CTRL, 32'h0);
    chk(rd, `SRC_CTRL_RST, 32'hffff_ffff);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1, 32'h1);
    chk(rd, 32'h0, 32'hffff_ffff);
    // sleep command refused while sleep is disabled
    apb(1'b1, `SRC_OFF_SLEEP, 32'h1);
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(sleeping), 32'h0, 32'h1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `SRC_OFF_CTRL, {28'h0, MODES[i], 1'b1});
      apb(1'b1, `SRC_OFF_SLEEP, 32'h1);
      repeat (2) @(posedge pclk);
      #1;
      chk(32'(dom), 32'(DEXP[i]), 32'(DMSK[i]));
      chk(32'(sleeping), 32'h1, 32'h1);
      apb(1'b0, `SRC_OFF_STAT, 32'h0);
      chk(rd, {27'h0, MODES[i], 2'h1}, 32'h1f);
      @(posedge pclk);
      irq_go[i % 3] <= 1'b1;
      wait_wake();
      irq_go <= 3'h0;
      #1;
      chk(32'(dom), 32'h3f, 32'h3f);
      apb(1'b0, `SRC_OFF_STAT, 32'h0);
      chk(rd, 32'h20, 32'h63);
      apb(1'b1, `SRC_OFF_STAT, 32'h60);
      apb(1'b0, `SRC_OFF_CTRL, 32'h0);
      chk(rd, {28'h0, MODES[i], 1'b1}, 32'hf);
    end
    // unused mode code leaves the mode in place
    apb(1'b1, `SRC_OFF_CTRL, 32'h9);
    apb(1'b0, `SRC_OFF_CTRL, 32'h0);
    chk(rd, 32'hf, 32'hf);
    // power-save woken by the async timer
    apb(1'b1, `SRC_OFF_CTRL, {28'h0, `SRC_M_PSV, 1'b1});
    apb(1'b1, `SRC_OFF_SLEEP, 32'h1);
    @(posedge pclk);
    tmr_irq <= 1'b1;
    wait_wake();
    tmr_irq <= 1'b0;
    apb(1'b0, `SRC_OFF_STAT, 32'h0);
    chk(rd, 32'h4c, 32'h7f);
    apb(1'b1, `SRC_OFF_STAT, 32'h60);
    // adc noise mode: peripheral irq ignored, adc irq wakes
    apb(1'b1, `SRC_OFF_CTRL, {28'h0, `SRC_M_ADC, 1'b1});
    apb(1'b1, `SRC_OFF_SLEEP, 32'h1);
    @(posedge pclk);
    per_irq <= 1'b1;
    repeat (8) @(posedge pclk);
    #1;
    chk(32'(sleeping), 32'h1, 32'h1);
    @(posedge pclk);
    adc_irq <= 1'b1;
    wait_wake();
    per_irq <= 1'b0;
    adc_irq <= 1'b0;
    apb(1'b0, `SRC_OFF_STAT, 32'h0);
    chk(rd, 32'h44, 32'h7f);
    apb(1'b1, `SRC_OFF_STAT, 32'h60);
    // idle wake by a peripheral interrupt
    apb(1'b1, `SRC_OFF_CTRL, 32'h1);
    apb(1'b1, `SRC_OFF_SLEEP, 32'h1);
    repeat (2) @(posedge pclk);
    per_irq <= 1'b1;
    wait_wake();
    per_irq <= 1'b0;
    apb(1'b0, `SRC_OFF_STAT, 32'h0);
    chk(rd, 32'h40, 32'h63);
    // pin reset: floats pins before any edge, keeps registers
    @(posedge pclk);
    rst_go <= 1'b1;
    @(posedge pclk);
    rst_go <= 1'b0;
    #1;
    chk(32'(dev_rst_n), 32'h0, 32'h1);
    chk(pin_oe_n, 32'hffff_ffff, 32'hffff_ffff);
    chk(pin_pu_en, `SRC_JTAG_PINS, `SRC_JTAG_PINS);
    repeat (12) @(posedge pclk);
    fuse <= 1'b0;
    #1;
    chk(32'(dev_rst_n), 32'h1, 32'h1);
    chk(pin_pu_en, core_pu_en, 32'hffff_ffff);
    apb(1'b0, `SRC_OFF_CTRL, 32'h0);
    chk(rd, 32'h1, 32'hf);
    give_verdict();
  end

  initial begin
    #100000;
    stall("finish");
  end
endmodule : sleep_and_reset_control_tb
